// ### design/ebcs_defs.svh
// Constants of the external bus cycle sequencer: offsets, fields, resets
`ifndef EBCS_DEFS_SVH
`define EBCS_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define EBCS_OFS_CTRL      8'h00
`define EBCS_OFS_TIM0      8'h04
`define EBCS_OFS_TIM1      8'h08
`define EBCS_OFS_CMD_ADDR  8'h0c
`define EBCS_OFS_CMD_DATA  8'h10
`define EBCS_OFS_STATUS    8'h14
`define EBCS_OFS_RDATA     8'h18

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define EBCS_CTRL_MUX      0
`define EBCS_CTRL_RDY_EN   1
`define EBCS_CTRL_RDY_POL  2
`define EBCS_CTRL_RDY_ASYN 3
`define EBCS_CTRL_W        4
`define EBCS_CTRL_RST      4'h0

// ----------------------------------------------------------------------
// Phase timing register fields (one register per chip select)
// ----------------------------------------------------------------------
`define EBCS_TIM_AB        0
`define EBCS_TIM_ABX_LSB   1
`define EBCS_TIM_C_LSB     3
`define EBCS_TIM_D         5
`define EBCS_TIM_E_LSB     6
`define EBCS_TIM_F_LSB     11
`define EBCS_TIM_W         13
`define EBCS_TIM_RST       13'h1fff

// ----------------------------------------------------------------------
// Command address register fields
// ----------------------------------------------------------------------
`define EBCS_CMD_BE_LSB    24
`define EBCS_CMD_WRITE     26
`define EBCS_CMD_W         27
`define EBCS_CMD_RST       27'h0000000

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define EBCS_STAT_BUSY     0
`define EBCS_STAT_EMPTY    1
`define EBCS_STAT_FULL     2
`define EBCS_STAT_RDVALID  3

// ----------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------
`define EBCS_ADDR_W        24
`define EBCS_DATA_W        16
`define EBCS_FIFO_W        43
`define EBCS_FIFO_DEPTH    32
`define EBCS_TCS_CYCLES    1

`endif

// ### design/ebcs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ebcs_fifo #(
  parameter int WIDTH = 43,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Both handshake sides
  ebcs_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             doPush;
  logic             doPop;

  // Full and empty come straight from the occupancy count
  assign port.pushReady = (count_q != (AW+1)'(DEPTH));
  assign port.popValid  = (count_q != '0);
  assign port.popData   = mem[rdPtr_q];
  assign doPush         = port.pushValid & port.pushReady;
  assign doPop          = port.popValid & port.popReady;

  // Storage; reads are guarded by the count
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_q] <= port.pushData;
    end
  end

  // Pointers wrap naturally, depth is a power of two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + AW'(1);
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + AW'(1);
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_q <= '0;
    end else begin
      case ({doPush, doPop})
        2'b10:   count_q <= count_q + (AW+1)'(1);
        2'b01:   count_q <= count_q - (AW+1)'(1);
        default: count_q <= count_q;
      endcase
    end
  end
endmodule : ebcs_fifo

// ### design/ebcs_fifo_if.sv
// Push and pop handshake signals of the command FIFO
`timescale 1ns/1ps
interface ebcs_fifo_if #(parameter int WIDTH = 43);
  logic             pushValid;
  logic             pushReady;
  logic [WIDTH-1:0] pushData;
  logic             popValid;
  logic             popReady;
  logic [WIDTH-1:0] popData;

  modport store    (input pushValid, pushData, popReady,
                    output pushReady, popValid, popData);
  modport producer (output pushValid, pushData, input pushReady);
  modport consumer (output popReady, input popValid, popData);
endinterface : ebcs_fifo_if

// ### design/ebcs_pkg.sv
// Types shared by the external bus cycle sequencer modules
package ebcs_pkg;
  `include "ebcs_defs.svh"

  // Bus cycle phases, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_CMD  = 6'b000100,
    ST_DSET = 6'b001000,
    ST_ACC  = 6'b010000,
    ST_HOLD = 6'b100000
  } ebcs_state_t;

  // One queued access
  typedef struct packed {
    logic                    write;
    logic [1:0]              byteEn;
    logic [`EBCS_ADDR_W-1:0] addr;
    logic [`EBCS_DATA_W-1:0] wdata;
  } ebcs_cmd_t;

  // Phase lengths, laid out as in the timing register
  typedef struct packed {
    logic [1:0] hold;
    logic [4:0] acc;
    logic       dset;
    logic [1:0] cmd;
    logic [1:0] abExt;
    logic       ab;
  } ebcs_tim_t;
endpackage : ebcs_pkg

// ### design/ebcs_top.sv
// External bus cycle sequencer with Wishbone register access
//
// Notes on behaviour
// (R1) Every access runs address, command, data setup, access, hold phases; the code skips a command, data setup or hold phase of zero length.
// (R2) Phase lengths come from the timing register of the chip select.
// (R3) Access phase lasts 1 to 32 units, optionally stretched by ready.
// (R4) Address phase is 1 or 2 units, plus 0 to 3 on window change.
// (R5) Data setup or tristate phase lasts 0 or 1 unit.
// (R6) Hold phase keeps address and write data for 0 to 3 units.
// (R7) Read data is captured on the edge that ends the read strobe.
// (R8) Address changes before strobe end cannot corrupt the captured read.
// (R9) External module holds read data until the read strobe rises.
// (R10) Multiplexed mode puts address, then write data, on shared lines.
// (R11) Demultiplexed mode puts write data on separate data lines.
// (R12) A 24-bit address is driven on the dedicated address lines.
// (R13) Chip selects, latch enable, byte high, read, byte write strobes.
// (R14) Reference clock output is the system clock itself.
// (R15) Latch enable is high in the address phase in multiplexed mode.
// (R16) Ready polarity is selected by configuration.
// (R17) Asynchronous ready passes one extra synchronizer stage.
// (R18) Ready inactive at sample point inserts a wait and samples again.
// (R19) Ready active at sample point ends the running bus cycle.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "ebcs_defs.svh"
module ebcs_top import ebcs_pkg::*; (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  // External bus control
  output      logic        referenceClockOut,
  output      logic [1:0]  chipSelectN,
  output      logic        addressLatchEnable,
  output      logic        byteHighEnableN,
  output      logic        readStrobeN,
  output      logic [1:0]  byteWriteStrobesN,
  input  wire logic        readyIn,
  // External address and data
  output      logic [23:0] addrLines,
  input  wire logic [15:0] muxedAddrDataIn,
  output      logic [15:0] muxedAddrDataOut,
  output      logic        muxedAddrDataOe,
  input  wire logic [15:0] dataLinesIn,
  output      logic [15:0] dataLinesOut,
  output      logic        dataLinesOe
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [`EBCS_CTRL_W-1:0] ctrl_q;
  logic [`EBCS_TIM_W-1:0]  tim0_q;
  logic [`EBCS_TIM_W-1:0]  tim1_q;
  logic [`EBCS_CMD_W-1:0]  cmdAddr_q;
  logic                    ack_q;
  logic [31:0]             rdBus_q;
  logic [31:0]             rdMux;
  logic [7:0]              wordAdr;
  logic                    wbReq;
  logic                    wbTake;
  logic                    pushStall;
  logic                    rdValid_q;
  logic [15:0]             rdData_q;
  ebcs_state_t             state_q;
  ebcs_state_t             stateD;
  logic [4:0]              cnt_q;
  logic [4:0]              cntD;
  logic                    popNow;
  ebcs_cmd_t               cmd_q;
  ebcs_cmd_t               head;
  ebcs_tim_t               tim;
  ebcs_tim_t               headTim;
  logic [7:0]              lastWin_q;
  logic                    winValid_q;
  logic                    winChange;
  logic                    rdySync1_q;
  logic                    rdySync2_q;
  logic                    rdySync3_q;
  logic                    rdySample;
  logic                    rdyActive;
  logic                    accDone;
  logic [15:0]             adSync1_q;
  logic [15:0]             adSync2_q;
  logic [15:0]             dSync1_q;
  logic [15:0]             dSync2_q;
  logic [23:0]             addrOut_q;
  logic [15:0]             adOut_q;
  logic                    adOe_q;
  logic [15:0]             dOut_q;
  logic                    dOe_q;
  logic                    busy;
  logic [31:0]             wrWord;

  ebcs_fifo_if #(.WIDTH(`EBCS_FIFO_W)) cmdFifo ();

  // Byte-lane merge for register writes
  function automatic logic [31:0] laneMerge(input logic [31:0] oldV,
                                            input logic [31:0] newV,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = oldV;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return res;
  endfunction : laneMerge

  // --------------------------------------------------------------------
  // Command FIFO
  // --------------------------------------------------------------------
  ebcs_fifo #(
    .WIDTH (`EBCS_FIFO_W),
    .DEPTH (`EBCS_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .port    (cmdFifo)
  );

  // --------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------
  // Full FIFO holds a data write off until room
  assign wordAdr   = {wb_adr_i[7:2], 2'b00};
  assign wbReq     = wb_cyc_i & wb_stb_i & ~ack_q;
  assign pushStall = wbReq & wb_we_i & (wordAdr == `EBCS_OFS_CMD_DATA)
                     & ~cmdFifo.pushReady;
  assign wbTake    = wbReq & ~pushStall;
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rdBus_q;

  // Queue entry is the staged address word plus the written data
  assign cmdFifo.pushValid = wbTake & wb_we_i
                             & (wordAdr == `EBCS_OFS_CMD_DATA);
  assign cmdFifo.pushData  = {cmdAddr_q, wb_dat_i[15:0]};

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    rdMux = 32'h00000000;
    case (wordAdr)
      `EBCS_OFS_CTRL:     rdMux = {28'h0000000, ctrl_q};
      `EBCS_OFS_TIM0:     rdMux = {19'h00000, tim0_q};
      `EBCS_OFS_TIM1:     rdMux = {19'h00000, tim1_q};
      `EBCS_OFS_CMD_ADDR: rdMux = {5'h00, cmdAddr_q};
      `EBCS_OFS_STATUS: begin
        rdMux[`EBCS_STAT_BUSY]    = busy;
        rdMux[`EBCS_STAT_EMPTY]   = ~cmdFifo.popValid;
        rdMux[`EBCS_STAT_FULL]    = ~cmdFifo.pushReady;
        rdMux[`EBCS_STAT_RDVALID] = rdValid_q;
      end
      `EBCS_OFS_RDATA:    rdMux = {16'h0000, rdData_q};
      default:            rdMux = 32'h00000000;
    endcase
  end

  // Ack one cycle after the request is taken, dropped the cycle after
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdBus_q <= 32'h00000000;
    end else begin
      ack_q <= wbTake;
      if (wbTake & ~wb_we_i) begin
        rdBus_q <= rdMux;
      end
    end
  end

  // Old value with the selected lanes replaced; rdMux zero-extends
  assign wrWord = laneMerge(rdMux, wb_dat_i, wb_sel_i);

  // Configuration registers; writes to other words are ignored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q    <= `EBCS_CTRL_RST;
      tim0_q    <= `EBCS_TIM_RST;
      tim1_q    <= `EBCS_TIM_RST;
      cmdAddr_q <= `EBCS_CMD_RST;
    end else if (wbTake & wb_we_i) begin
      case (wordAdr)
        `EBCS_OFS_CTRL:     ctrl_q    <= wrWord[`EBCS_CTRL_W-1:0];
        `EBCS_OFS_TIM0:     tim0_q    <= wrWord[`EBCS_TIM_W-1:0];
        `EBCS_OFS_TIM1:     tim1_q    <= wrWord[`EBCS_TIM_W-1:0];
        `EBCS_OFS_CMD_ADDR: cmdAddr_q <= wrWord[`EBCS_CMD_W-1:0];
        default: ;
      endcase
    end
  end

  // Read-valid flag: set by a finished read, cleared by reading the data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdValid_q <= 1'b0;
    end else if (state_q == ST_ACC && stateD != ST_ACC && !cmd_q.write) begin
      rdValid_q <= 1'b1; // Set wins over a clear in the same cycle
    end else if (wbTake & ~wb_we_i & (wordAdr == `EBCS_OFS_RDATA)) begin
      rdValid_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Ready: two stages, a third only in asynchronous mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdySync1_q <= 1'b0;
      rdySync2_q <= 1'b0;
      rdySync3_q <= 1'b0;
    end else begin
      rdySync1_q <= readyIn;
      rdySync2_q <= rdySync1_q;
      rdySync3_q <= rdySync2_q; // [R17]
    end
  end

  // Data lines; held data makes the lag harmless
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      adSync1_q <= 16'h0000;
      adSync2_q <= 16'h0000;
      dSync1_q  <= 16'h0000;
      dSync2_q  <= 16'h0000;
    end else begin
      adSync1_q <= muxedAddrDataIn;
      adSync2_q <= adSync1_q;
      dSync1_q  <= dataLinesIn;
      dSync2_q  <= dSync1_q;
    end
  end

  assign rdySample = ctrl_q[`EBCS_CTRL_RDY_ASYN] ? rdySync3_q
                                                 : rdySync2_q; // [R17]
  assign rdyActive = ctrl_q[`EBCS_CTRL_RDY_POL] ? rdySample
                                                : ~rdySample; // [R16]

  // --------------------------------------------------------------------
  // Phase sequencer
  // --------------------------------------------------------------------
  assign head      = ebcs_cmd_t'(cmdFifo.popData);
  assign headTim   = ebcs_tim_t'(head.addr[23] ? tim1_q : tim0_q); // [R2]
  assign tim       = ebcs_tim_t'(cmd_q.addr[23] ? tim1_q : tim0_q); // [R2]
  assign winChange = ~winValid_q | (head.addr[23:16] != lastWin_q);
  assign cmdFifo.popReady = popNow;
  // Access phase may end once its count is spent and ready allows
  assign accDone   = ~ctrl_q[`EBCS_CTRL_RDY_EN] | rdyActive; // [R19]

  // Next phase and length counter; a zero-length phase is skipped
  always_comb begin
    stateD = state_q;
    cntD   = (cnt_q != 5'd0) ? cnt_q - 5'd1 : 5'd0;
    popNow = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cmdFifo.popValid) begin
          popNow = 1'b1;
          stateD = ST_ADDR;
          cntD   = {4'h0, headTim.ab}
                   + (winChange ? {3'h0, headTim.abExt} : 5'd0); // [R4]
        end
      end
      ST_ADDR: begin
        if (cnt_q == 5'd0) begin
          if (tim.cmd != 2'd0) begin
            stateD = ST_CMD;
            cntD   = {3'h0, tim.cmd} - 5'd1;
          end else if (tim.dset) begin
            stateD = ST_DSET; // [R5]
            cntD   = 5'd0;
          end else begin
            stateD = ST_ACC;
            cntD   = tim.acc; // [R3]
          end
        end
      end
      ST_CMD: begin
        if (cnt_q == 5'd0) begin
          stateD = tim.dset ? ST_DSET : ST_ACC; // [R1] [R5]
          cntD   = tim.dset ? 5'd0 : tim.acc;
        end
      end
      ST_DSET: begin
        if (cnt_q == 5'd0) begin
          stateD = ST_ACC;
          cntD   = tim.acc; // [R3]
        end
      end
      ST_ACC: begin
        // Inactive ready keeps the phase, sampled again next cycle
        if (cnt_q == 5'd0 && accDone) begin // [R18] [R19]
          stateD = (tim.hold != 2'd0) ? ST_HOLD : ST_IDLE; // [R6]
          cntD   = {3'h0, tim.hold} - 5'd1;
        end
      end
      ST_HOLD: begin
        if (cnt_q == 5'd0) begin
          stateD = ST_IDLE; // [R1]
        end
      end
      default: begin
        stateD = ST_IDLE;
        cntD   = 5'd0;
      end
    endcase
  end

  // State, counter and the access being run
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 5'd0;
      cmd_q      <= '0;
      lastWin_q  <= 8'h00;
      winValid_q <= 1'b0;
    end else begin
      state_q <= stateD; // [R1]
      cnt_q   <= cntD;
      if (popNow) begin
        cmd_q      <= head;
        lastWin_q  <= head.addr[23:16];
        winValid_q <= 1'b1;
      end
    end
  end

  // Capture on the edge raising the read strobe;
  // later address moves cannot disturb it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_q <= 16'h0000;
    end else if (state_q == ST_ACC && stateD != ST_ACC && !cmd_q.write) begin
      rdData_q <= ctrl_q[`EBCS_CTRL_MUX] ? adSync2_q
                                         : dSync2_q; // [R7] [R8] [R9]
    end
  end

  // --------------------------------------------------------------------
  // Address and data drivers
  // --------------------------------------------------------------------
  // Address stays on the pins; only enables are released
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addrOut_q <= 24'h000000;
      adOut_q   <= 16'h0000;
      adOe_q    <= 1'b0;
      dOut_q    <= 16'h0000;
      dOe_q     <= 1'b0;
    end else if (popNow) begin
      addrOut_q <= head.addr; // [R12]
      adOut_q   <= head.addr[15:0]; // [R10]
      adOe_q    <= ctrl_q[`EBCS_CTRL_MUX];
      dOe_q     <= 1'b0;
    end else if ((state_q == ST_ADDR || state_q == ST_CMD)
                 && (stateD == ST_DSET || stateD == ST_ACC)) begin
      if (ctrl_q[`EBCS_CTRL_MUX]) begin
        adOut_q <= cmd_q.wdata; // [R10]
        adOe_q  <= cmd_q.write; // Read turns the shared lines round
      end else if (cmd_q.write) begin
        dOut_q <= cmd_q.wdata; // [R11]
        dOe_q  <= 1'b1;
      end
    end else if (stateD == ST_IDLE) begin
      adOe_q <= 1'b0;
      dOe_q  <= 1'b0;
    end
  end

  assign addrLines        = addrOut_q;
  assign muxedAddrDataOut = adOut_q;
  assign muxedAddrDataOe  = adOe_q;
  assign dataLinesOut     = dOut_q;
  assign dataLinesOe      = dOe_q;

  // --------------------------------------------------------------------
  // Control strobes
  // --------------------------------------------------------------------
  // Decoded from the one-hot phase
  assign busy = (state_q != ST_IDLE) | cmdFifo.popValid;
  assign chipSelectN[0] = ~((state_q != ST_IDLE) & ~cmd_q.addr[23]); // [R13]
  assign chipSelectN[1] = ~((state_q != ST_IDLE) & cmd_q.addr[23]);  // [R13]
  assign addressLatchEnable = (state_q == ST_ADDR)
                              & ctrl_q[`EBCS_CTRL_MUX]; // [R15]
  assign byteHighEnableN = ~((state_q != ST_IDLE)
                             & cmd_q.byteEn[1]); // [R13]
  assign readStrobeN = ~((state_q == ST_ACC) & ~cmd_q.write); // [R13]
  assign byteWriteStrobesN[0] = ~((state_q == ST_ACC) & cmd_q.write
                                  & cmd_q.byteEn[0]); // [R13]
  assign byteWriteStrobesN[1] = ~((state_q == ST_ACC) & cmd_q.write
                                  & cmd_q.byteEn[1]); // [R13]

  // Reference clock is the system clock passed straight to the pad
  assign referenceClockOut = clk_sys; // [R14]
endmodule : ebcs_top

// ### verif/ebcs_mem_model.sv
// Behavioural external memory answering the sequencer's bus cycles
`timescale 1ns/1ps
module ebcs_mem_model (
  // Memory-side pins
  input wire logic        clk_sys, readStrobeN, addressLatchEnable,
  input wire logic [1:0]  byteWriteStrobesN,
  input wire logic [23:0] addrLines,
  input wire logic [15:0] wdWire, muxWire,
  // Ready setup
  input wire logic        rdyPol,
  input wire logic [7:0]  waitCyc,
  // Drive and observations
  output logic            readyIn,
  output logic [15:0]     mdl, wd, la,
  output logic [1:0]      ws,
  output logic [7:0]      cmdLen, aleLen
);
  logic [15:0] rv;
  logic [7:0]  c, a;
  logic        cmd;
  assign cmd = !readStrobeN || !(&byteWriteStrobesN);
  // Released lines show the inverse
  assign mdl = readStrobeN ? ~rv : rv;
  // Ready active after waitCyc strobe cycles
  assign readyIn = (c >= waitCyc) ~^ rdyPol;
  // Strobe and latch lengths, write capture
  always @(posedge clk_sys) begin
    if (readStrobeN)
      rv <= addrLines[15:0] ^ 16'h5a3c;
    c <= cmd ? c + 8'h01 : 8'h00;
    if (!cmd && c != 8'h00)
      cmdLen <= c;
    a <= addressLatchEnable ? a + 8'h01 : 8'h00;
    if (!addressLatchEnable && a != 8'h00)
      aleLen <= a;
    if (addressLatchEnable)
      la <= muxWire;
    if (!(&byteWriteStrobesN)) begin
      wd <= wdWire;
      ws <= byteWriteStrobesN;
    end
  end
endmodule : ebcs_mem_model

// ### verif/ebcs_props.sv
// Port-level checks of the external bus cycle sequencer
`timescale 1ns/1ps
module ebcs_props (
  // Clock, reset, bus
  input wire logic        clk_sys, rst, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic [7:0]  wb_adr_i,
  // External bus pins
  input wire logic        referenceClockOut, addressLatchEnable,
  input wire logic        readStrobeN, muxedAddrDataOe, dataLinesOe,
  input wire logic [1:0]  chipSelectN, byteWriteStrobesN,
  input wire logic [23:0] addrLines,
  input wire logic [15:0] muxedAddrDataOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // One ack pulse, a cycle after a non-stalling request
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    && wb_adr_i[7:2] != 6'h04 |=> wb_ack_o) else $error("ack late");
  // A flopped copy would show high here
  a_ref_clk: assert property (!referenceClockOut)
    else $error("reference clock out of phase");
  a_cs_decode: assert property (chipSelectN != 2'h3 |->
    chipSelectN == (addrLines[23] ? 2'h1 : 2'h2)) else $error("bad select");
  a_cmd_excl: assert property (!readStrobeN |-> &byteWriteStrobesN)
    else $error("read and write strobes together");
  a_cmd_cs: assert property ($fell(readStrobeN) |->
    $past(chipSelectN) != 2'h3) else $error("strobe without address phase");
  a_ale_addr: assert property (addressLatchEnable |->
    muxedAddrDataOe && muxedAddrDataOut == addrLines[15:0])
    else $error("latch enable without address");
  a_rd_float: assert property (!readStrobeN |-> !muxedAddrDataOe
    && !dataLinesOe) else $error("lines driven during read");
  a_rd_addr: assert property (!readStrobeN ##1 !readStrobeN |->
    $stable(addrLines)) else $error("address moved in read");
endmodule : ebcs_props

bind ebcs_top ebcs_props u_props (.*);

// ### verif/tb_external_bus_cycle_sequencer.sv
// Self-checking bench for the external bus cycle sequencer
`timescale 1ns/1ps
module tb_external_bus_cycle_sequencer;
  logic        clk_sys = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0;
  logic        rdyPol = 1'b1, muxMode = 1'b0;
  logic        wbAck, ale, rdN, rdy, muxOe, datOe;
  logic [1:0]  csN, wrN, ws;
  logic [7:0]  adr = 8'h00, waitCyc = 8'h00, cmdLen, aleLen;
  logic [15:0] muxO, datO, mdl, wd, la, muxW, datW;
  logic [23:0] addrL;
  logic [31:0] dat = 32'h0, rd, wbDatO;
  int          checks = 0, fail_count = 0, n, s0, base;

  // Enabled driver wins the lines
  assign muxW = muxOe ? muxO : mdl;
  assign datW = datOe ? datO : mdl;
  always #12.5 clk_sys = ~clk_sys;

  ebcs_top dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .referenceClockOut(),
    .chipSelectN(csN), .addressLatchEnable(ale), .byteHighEnableN(),
    .readStrobeN(rdN), .byteWriteStrobesN(wrN), .readyIn(rdy),
    .addrLines(addrL), .muxedAddrDataIn(muxW), .muxedAddrDataOut(muxO),
    .muxedAddrDataOe(muxOe), .dataLinesIn(datW), .dataLinesOut(datO),
    .dataLinesOe(datOe));
  ebcs_mem_model mem (.clk_sys(clk_sys), .readStrobeN(rdN),
    .addressLatchEnable(ale), .byteWriteStrobesN(wrN), .addrLines(addrL),
    .wdWire(muxMode ? muxW : datW), .muxWire(muxW), .rdyPol(rdyPol),
    .waitCyc(waitCyc), .readyIn(rdy), .mdl(mdl), .wd(wd), .la(la),
    .ws(ws), .cmdLen(cmdLen), .aleLen(aleLen));

  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 9000);
    rd = wbDatO;
    req <= 1'b0;
    @(posedge clk_sys);
    if (n >= 9000) begin
      fail_count++;
      final_report();
    end
  endtask : wb

  // Wait until idle and empty
  task automatic idle();
    s0 = 0;
    do begin
      wb(1'b0, 8'h14, 32'h0);
      s0++;
    end while (rd[1:0] !== 2'b10 && s0 < 3000);
    if (s0 >= 3000) begin
      fail_count++;
      final_report();
    end
  endtask : idle

  task automatic go(input logic [26:0] cmd, input logic [15:0] d);
    wb(1'b1, 8'h0c, {5'h00, cmd});
    wb(1'b1, 8'h10, {16'h0000, d});
    idle();
  endtask : go

  task automatic t_reset();
    logic [7:0]  a[5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h1c};
    logic [31:0] e[5] = '{32'h0, 32'h1fff, 32'h1fff, 32'h2, 32'h0};
    wb(1'b1, 8'h14, 32'hffffffff);
    foreach (a[i]) begin
      wb(1'b0, a[i], 32'h0);
      chk("reset value", rd, e[i]);
    end
  endtask : t_reset

  task automatic t_demux();
    wb(1'b1, 8'h04, 32'h08e0);
    go(27'h7001234, 16'hbeef);
    chk("demux write data", wd, 16'hbeef);
    chk("both write strobes", ws, 2'h0);
    go(27'h5001234, 16'h00aa);
    chk("low strobe only", ws, 2'h2);
    go(27'h3804321, 16'h0000);
    wb(1'b0, 8'h18, 32'h0);
    chk("read data", rd, 32'h4321 ^ 32'h5a3c);
    wb(1'b0, 8'h14, 32'h0);
    chk("read valid cleared", rd[3], 1'b0);
  endtask : t_demux

  // Sync, async, low-active ready
  task automatic t_ready();
    waitCyc <= 8'h06;
    wb(1'b1, 8'h00, 32'h6);
    go(27'h3004444, 16'h0000);
    base = cmdLen;
    chk("ready stretch", base >= 8, 1'b1);
    wb(1'b1, 8'h00, 32'he);
    go(27'h3004444, 16'h0000);
    chk("async extra wait", cmdLen > base, 1'b1);
    rdyPol <= 1'b0;
    wb(1'b1, 8'h00, 32'h2);
    go(27'h3004444, 16'h0000);
    chk("low-active ready", cmdLen, base);
    wb(1'b0, 8'h18, 32'h0);
    chk("data after ready", rd, 32'h4444 ^ 32'h5a3c);
  endtask : t_ready

  // Slow memory fills the FIFO; pushes stall
  task automatic t_fifo();
    rdyPol <= 1'b1;
    waitCyc <= 8'h3c;
    wb(1'b1, 8'h00, 32'h6);
    wb(1'b1, 8'h0c, 32'h7000010);
    repeat (40) wb(1'b1, 8'h10, 32'h1);
    wb(1'b0, 8'h14, 32'h0);
    chk("fifo full", rd[2:1], 2'h2);
    idle();
    chk("fifo drained", wd, 16'h0001);
  endtask : t_fifo

  task automatic t_mux();
    muxMode <= 1'b1;
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b1, 8'h04, 32'h08e7);
    go(27'h7125678, 16'h1357);
    chk("latched address", la, 16'h5678);
    chk("mux write data", wd, 16'h1357);
    chk("new window", aleLen, 8'h05);
    go(27'h3125000, 16'h0000);
    chk("same window", aleLen, 8'h02);
    wb(1'b0, 8'h18, 32'h0);
    chk("mux read data", rd, 32'h5000 ^ 32'h5a3c);
  endtask : t_mux

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_demux();
    t_ready();
    t_fifo();
    t_mux();
    final_report();
  end
endmodule : tb_external_bus_cycle_sequencer
